// *** logic/dsw_pkg.sv ***
// Package for the serial write port: word layout, modes, timing figures.
// Assumes a 100 MHz system clock sampling the serial pins.
`default_nettype none
package dsw_pkg;
   // ****************************************
   // Word layout
   // ****************************************
   localparam int WORD_BITS   = 16;
   localparam int CODE_BITS   = 12;
   localparam int MODE_BITS   = 2;
   localparam int CODE_LSB    = 0;
   localparam int MODE_LSB    = 12;
   localparam int CNT_BITS    = 5;
   localparam logic [4:0] LAST_EDGE = 5'h10;
   localparam logic [11:0] CODE_RESET = 12'h000;
   localparam logic [11:0] CODE_FULL  = 12'hfff;
   localparam int FIFO_DEPTH  = 16;
   localparam int FIFO_AW     = 4;

   // ****************************************
   // Operating modes
   // ****************************************
   typedef enum logic [1:0] {
      DSW_MODE_NORMAL = 2'h0,
      DSW_MODE_PD_1K  = 2'h1,
      DSW_MODE_PD_100K = 2'h2,
      DSW_MODE_PD_TRI = 2'h3
   } dsw_mode_t;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS   = 10;
   localparam int SYNC_HIGH_MIN_NS = 33;
   localparam int SYNC_HIGH_CYC =
      (SYNC_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : dsw_pkg
`default_nettype wire

// *** logic/dsw_word_if.sv ***
// Carrier for applied words between the front end and the FIFO.
// Assumes one clock domain shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface dsw_word_if;
   logic        valid;
   logic        ready;
   logic [15:0] data;
   modport src  (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface : dsw_word_if
`default_nettype wire

// *** logic/dsw_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module dsw_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [WIDTH-1:0] rd_q;
   logic             rd_valid;
   wire              full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                             (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   wire              empty = (wr_ptr == rd_ptr);
   wire              push  = in_valid_i && !full;
   // Output register refills when empty or being drained
   wire              pop   = !empty && (!rd_valid || out_ready_i);

   assign in_ready_o  = !full;
   assign out_valid_o = rd_valid;
   assign out_data_o  = rd_q;

   // Storage write
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end

   // Pointers and registered read data
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         rd_valid <= 1'b0;
         rd_q     <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) begin
            rd_ptr   <= rd_ptr + 1'b1;
            rd_q     <= mem[rd_ptr[AW-1:0]];
            rd_valid <= 1'b1;
         end else if (out_ready_i) begin
            rd_valid <= 1'b0;
         end
      end
   end

   a_fifo_no_overflow : assert property (@(posedge clk_i) disable iff (reset_i)
      full |-> ##1 (wr_ptr == $past(wr_ptr)))
      else $error("FIFO pointer moved while full");
endmodule : dsw_fifo
`default_nettype wire

// *** logic/dsw_top.sv ***
// Serial write port of a 12-bit converter: frame select, shift clock, data.
// Assumes pins are asynchronous to clk_i and sampled through two flops.
`timescale 1ns/10ps
`default_nettype none
module dsw_top (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        sync_n_i,
   input  wire logic        sclk_i,
   input  wire logic        din_i,
   output logic      [11:0] code_o,
   output logic      [1:0]  mode_o,
   output logic             powered_down_o,
   output logic             pd_1k_o,
   output logic             pd_100k_o,
   output logic             pd_tristate_o,
   output logic             frame_abort_o,
   output logic             word_busy_o
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic       sclk_prev;

   // Two flops per pin; only the second stage feeds logic
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         // Parked at the idle level so no false clock edge follows reset
         sync_a    <= '1;
         sync_b    <= '1;
         sclk_prev <= 1'b1;
      end else begin
         sync_a    <= {sync_n_i, sclk_i, din_i};
         sync_b    <= sync_a;
         sclk_prev <= sync_b[1];
      end
   end

   wire sel_n   = sync_b[2];
   wire sclk_s  = sync_b[1];
   wire din_s   = sync_b[0];
   wire sclk_fall = sclk_prev && !sclk_s;

   // ****************************************
   // Frame state machine
   // ****************************************
   typedef enum logic [1:0] {
      DSW_IDLE,
      DSW_SHIFT,
      DSW_DONE
   } dsw_state_t;

   dsw_state_t                     state;
   dsw_state_t                     next_state;
   logic [dsw_pkg::WORD_BITS-1:0] shreg;
   logic [dsw_pkg::CNT_BITS-1:0]  bit_cnt;

   function automatic logic [dsw_pkg::WORD_BITS-1:0] shift_in(
      input logic [dsw_pkg::WORD_BITS-1:0] cur,
      input logic                          bit_in);
      shift_in = {cur[dsw_pkg::WORD_BITS-2:0], bit_in}; // MSB first
   endfunction : shift_in

   wire take_bit  = (state == DSW_SHIFT) && sclk_fall;
   wire last_bit  = take_bit &&
                    (bit_cnt == dsw_pkg::LAST_EDGE - 5'h01);
   wire early_end = (state == DSW_SHIFT) && sel_n;
   wire [dsw_pkg::WORD_BITS-1:0] word_now = shift_in(shreg, din_s);

   // Next-state decode
   always_comb begin
      next_state = state;
      case (state)
         DSW_IDLE:  if (!sel_n) next_state = DSW_SHIFT;
         DSW_SHIFT: begin
            if (sel_n) next_state = DSW_IDLE;
            else if (last_bit) next_state = DSW_DONE;
         end
         DSW_DONE:  if (sel_n) next_state = DSW_IDLE;
         default:   next_state = DSW_IDLE;
      endcase
   end

   // Shift register and edge counter; cleared on every abort and once the
   // sixteenth bit has left through word_now, so the count stays below 16
   always_ff @(posedge clk_i) begin
      if (reset_i || state != DSW_SHIFT || sel_n || last_bit) begin
         shreg   <= '0;
         bit_cnt <= '0;
      end else if (take_bit) begin
         shreg   <= word_now;
         bit_cnt <= bit_cnt + 5'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) state <= DSW_IDLE;
      else         state <= next_state;
   end

   // ****************************************
   // Applied-word FIFO
   // ****************************************
   // Words queue here so a burst of frames is never lost; the apply side
   // drains one word a cycle, so the queue only fills if held.
   dsw_word_if wq ();
   assign wq.valid = last_bit && !sel_n;
   assign wq.data  = word_now;

   logic                          app_valid;
   logic [dsw_pkg::WORD_BITS-1:0] app_data;

   dsw_fifo #(
      .WIDTH (dsw_pkg::WORD_BITS),
      .DEPTH (dsw_pkg::FIFO_DEPTH),
      .AW    (dsw_pkg::FIFO_AW)
   ) u_fifo (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .in_valid_i  (wq.valid),
      .in_ready_o  (wq.ready),
      .in_data_i   (wq.data),
      .out_valid_o (app_valid),
      .out_ready_i (1'b1),
      .out_data_o  (app_data)
   );

   // ****************************************
   // Code and mode registers
   // ****************************************
   wire [dsw_pkg::CODE_BITS-1:0] next_code =
      app_data[dsw_pkg::CODE_LSB +: dsw_pkg::CODE_BITS];
   wire [dsw_pkg::MODE_BITS-1:0] next_mode =
      app_data[dsw_pkg::MODE_LSB +: dsw_pkg::MODE_BITS];

   // Code and mode update together from one word
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         code_o <= dsw_pkg::CODE_RESET;
         mode_o <= dsw_pkg::DSW_MODE_NORMAL;
      end else if (app_valid) begin
         code_o <= next_code;
         mode_o <= next_mode;
      end
   end

   // Mode decode to power-down controls
   assign powered_down_o = (mode_o != dsw_pkg::DSW_MODE_NORMAL);
   assign pd_1k_o        = (mode_o == dsw_pkg::DSW_MODE_PD_1K);
   assign pd_100k_o      = (mode_o == dsw_pkg::DSW_MODE_PD_100K);
   assign pd_tristate_o  = (mode_o == dsw_pkg::DSW_MODE_PD_TRI);

   // Status flags, registered
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         frame_abort_o <= 1'b0;
         word_busy_o   <= 1'b0;
      end else begin
         frame_abort_o <= early_end;
         word_busy_o   <= (next_state == DSW_SHIFT);
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   // Counter and framing: the count never reaches sixteen, and a high
   // select or an idle state holds it at zero
   a_count_bound : assert property (
      @(posedge clk_i) disable iff (reset_i)
      bit_cnt < dsw_pkg::LAST_EDGE)
      else $error("Edge count passed sixteen");
   a_idle_no_shift : assert property (
      @(posedge clk_i) disable iff (reset_i)
      (state == DSW_IDLE) |-> ##1 (bit_cnt == 5'h00))
      else $error("Counter moved outside a frame");
   a_select_clears : assert property (
      @(posedge clk_i) disable iff (reset_i)
      sel_n |=> (bit_cnt == 5'h00))
      else $error("Counter kept while select high");
   a_busy_shift : assert property (
      @(posedge clk_i) disable iff (reset_i)
      ((state == DSW_SHIFT) && !sel_n && !last_bit) |=> word_busy_o)
      else $error("Busy flag low inside a frame");
   a_shift_sample : assert property (
      @(posedge clk_i) disable iff (reset_i)
      (take_bit && !last_bit && !sel_n) |=> shreg[0] == $past(din_s))
      else $error("Bit not sampled on falling edge");

   // Apply path: FIFO write, FIFO output register, then the code
   // register, so the word shows three cycles after the last edge
   a_apply_word : assert property (
      @(posedge clk_i) disable iff (reset_i)
      wq.valid |-> ##3 (code_o ==
         $past(wq.data[dsw_pkg::CODE_LSB +: dsw_pkg::CODE_BITS], 3)))
      else $error("Code not applied three cycles after last edge");
   a_push_ready : assert property (
      @(posedge clk_i) disable iff (reset_i)
      wq.valid |-> wq.ready)
      else $error("Word offered to a full queue");
   a_code_hold : assert property (
      @(posedge clk_i) disable iff (reset_i)
      !app_valid |=> $stable(code_o) && $stable(mode_o))
      else $error("Code or mode moved without a word");
   a_code_taken : assert property (
      @(posedge clk_i) disable iff (reset_i)
      app_valid |=> code_o ==
         $past(app_data[dsw_pkg::CODE_LSB +: dsw_pkg::CODE_BITS]))
      else $error("Code taken from wrong bits");
   a_field_split : assert property (
      @(posedge clk_i) disable iff (reset_i)
      app_valid |=> mode_o ==
         $past(app_data[dsw_pkg::MODE_LSB +: dsw_pkg::MODE_BITS]))
      else $error("Mode taken from wrong bits");

   // Aborted frames: nothing applied, one pulse, shift state wiped
   a_abort_keeps : assert property (
      @(posedge clk_i) disable iff (reset_i)
      (early_end && !app_valid) |=> $stable(code_o) && $stable(mode_o))
      else $error("Aborted frame changed code or mode");
   a_abort_pulse : assert property (
      @(posedge clk_i) disable iff (reset_i)
      early_end |=> frame_abort_o && (state == DSW_IDLE))
      else $error("Abort not flagged");
   a_abort_single : assert property (
      @(posedge clk_i) disable iff (reset_i)
      frame_abort_o |=> !frame_abort_o)
      else $error("Abort flag held longer than a cycle");
   a_abort_clears : assert property (
      @(posedge clk_i) disable iff (reset_i)
      early_end |=> (bit_cnt == 5'h00) && (shreg == '0))
      else $error("Partial word kept after abort");

   // After the sixteenth edge the port waits for select to rise
   a_done_ignores : assert property (
      @(posedge clk_i) disable iff (reset_i)
      (state == DSW_DONE) |-> !wq.valid)
      else $error("Word pushed after sixteenth edge");
   a_done_hold : assert property (
      @(posedge clk_i) disable iff (reset_i)
      ((state == DSW_DONE) && !sel_n) |=> (state == DSW_DONE))
      else $error("Left done state with select low");

   // Mode decode: at most one load choice at a time
   a_mode_decode : assert property (
      @(posedge clk_i) disable iff (reset_i)
      powered_down_o == (pd_1k_o || pd_100k_o || pd_tristate_o))
      else $error("Power-down decode mismatch");
   a_pd_onehot : assert property (
      @(posedge clk_i) disable iff (reset_i)
      $onehot0({pd_1k_o, pd_100k_o, pd_tristate_o}))
      else $error("Two power-down loads chosen");

   // Reset clears code and mode on the edge that sees it
   a_reset_zero : assert property (
      @(posedge clk_i)
      reset_i |=> (code_o == dsw_pkg::CODE_RESET) &&
                  (mode_o == dsw_pkg::DSW_MODE_NORMAL))
      else $error("Code not zero after reset");

   c_full_frame : cover property (@(posedge clk_i) wq.valid);
   c_abort      : cover property (@(posedge clk_i) early_end && bit_cnt > 5'h0);
   c_tristate   : cover property (@(posedge clk_i) pd_tristate_o);
   c_done_hold  : cover property (@(posedge clk_i) state == DSW_DONE && sclk_fall);
endmodule : dsw_top
`default_nettype wire

// *** tb/dsw_host_model.sv ***
// Host master model for the three-wire write port of the converter.
// Assumes clk_i is the 100 MHz bench clock; shift clock runs at 1/16 of it.
`timescale 1ns/10ps
`default_nettype none
module dsw_host_model (
   input  wire logic clk_i,
   output logic      sync_n_o,
   output logic      sclk_o,
   output logic      din_o
);
   localparam int HALF = 8;  // 160 ns shift clock, far under the top rate

   // Idle: select high, shift clock parked high, no free-running clock
   initial begin
      sync_n_o = 1'b1;
      sclk_o   = 1'b1;
      din_o    = 1'b0;
   end

   // ****************************************
   // Frame driver
   // ****************************************
   // Sends nfall falling edges, MSB first; past 16 the data line toggles.
   // With sel low the select pin stays high, so the edges are unframed.
   task automatic send(input logic [15:0] word, input int nfall,
                       input logic sel);
      int i;
      @(posedge clk_i);
      sync_n_o <= ~sel;
      repeat (HALF) @(posedge clk_i);
      for (i = 0; i < nfall; i++) begin
         din_o <= (i < 16) ? word[15 - i] : ~din_o;
         repeat (HALF) @(posedge clk_i);
         sclk_o <= 1'b0;
         repeat (HALF) @(posedge clk_i);
         sclk_o <= 1'b1;
      end
      repeat (HALF) @(posedge clk_i);
      sync_n_o <= 1'b1;
      din_o    <= ~din_o;  // Released line must not look like held data
      repeat (HALF) @(posedge clk_i);
   endtask : send
endmodule : dsw_host_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the serial write port top.
// Assumes the host model drives all pins; the FIFO drains internally.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        clk_i   = 1'b0;
   logic        reset_i = 1'b1;
   logic        sync_n, sclk, din;
   logic [11:0] code_o;
   logic [1:0]  mode_o;
   logic        pd_o, pd_1k_o, pd_100k_o, pd_tri_o, abort_o, busy_o;
   int          miscompares = 0;
   int          checks      = 0;
   int          aborts      = 0;
   int          busy_cyc    = 0;
   int          exp_code    = 0;
   int          exp_mode    = 0;
   int          seed        = 32'h93e3;
   int          m;
   logic [15:0] w;

   always #5 clk_i = ~clk_i;

   dsw_host_model host (.clk_i(clk_i), .sync_n_o(sync_n), .sclk_o(sclk),
                        .din_o(din));
   dsw_top uut (.clk_i(clk_i), .reset_i(reset_i), .sync_n_i(sync_n),
                .sclk_i(sclk), .din_i(din), .code_o(code_o),
                .mode_o(mode_o), .powered_down_o(pd_o),
                .pd_1k_o(pd_1k_o), .pd_100k_o(pd_100k_o),
                .pd_tristate_o(pd_tri_o), .frame_abort_o(abort_o),
                .word_busy_o(busy_o));

   // Abort pulses and busy cycles pass between checks: count them here
   always @(posedge clk_i) begin
      if (abort_o === 1'b1) aborts <= aborts + 1;
      if (busy_o === 1'b1) busy_cyc <= busy_cyc + 1;
   end

   // ****************************************
   // Checking helpers
   // ****************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp,
                        input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic compare_all(input int exp_ab);
      check({4'h0, code_o}, exp_code[15:0], "code");
      check({14'h0, mode_o}, exp_mode[15:0], "mode");
      check({12'h0, pd_o, pd_1k_o, pd_100k_o, pd_tri_o},
            {12'h0, exp_mode != 0, exp_mode == 1, exp_mode == 2,
             exp_mode == 3}, "decode");
      check(aborts[15:0], exp_ab[15:0], "aborts");
      check({15'h0, busy_o}, 16'h0, "busy");
   endtask : compare_all

   // Model applies a word only for a framed run of at least 16 edges
   task automatic frame(input logic [15:0] word, input int n,
                        input logic sel);
      int ab;
      int bb;
      int i;
      int q[$];
      ab = aborts;
      bb = busy_cyc;
      host.send(word, n, sel);
      repeat (2) @(posedge clk_i);
      // Bits the port shifts, first received at the front of the queue
      for (i = 0; i < n && i < 16 && sel; i++) q.push_back(word[15 - i]);
      if (q.size() == 16) begin
         exp_mode = q[2] * 2 + q[3];
         exp_code = 0;
         for (i = 4; i < 16; i++) exp_code = exp_code * 2 + q[i];
      end
      compare_all((sel && n < 16) ? ab + 1 : ab);
      check({15'h0, busy_cyc != bb}, {15'h0, sel}, "busy seen");
   endtask : frame

   task automatic test_done;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      compare_all(0);
      frame(16'hcfff, 16, 1'b1);
      frame(16'h0000, 16, 1'b1);
      for (m = 0; m < 8; m++) begin
         w = 16'($random(seed));
         w[13:12] = m[1:0];
         frame(w, 16, 1'b1);
      end
      frame(16'($random(seed)), 15, 1'b1);
      frame(16'($random(seed)), 3, 1'b1);
      frame(16'($random(seed)), 20, 1'b1);
      frame(16'($random(seed)), 16, 1'b0);
      // Mid-run reset: code and mode fall back to zero
      reset_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      exp_code = 0;
      exp_mode = 0;
      compare_all(aborts);
      frame(16'h1a5c, 16, 1'b1);
      test_done();
   end

   // Hang guard: a stall counts as a mismatch and ends the run
   initial begin
      repeat (90000) @(posedge clk_i);
      miscompares++;
      test_done();
   end
endmodule : tb_top
`default_nettype wire
